// ### shared/nand_seq_map.vh
/*
  register offsets, field positions, reset values and timing counts of the
  nand bus timing sequencer; assumes a single 50 MHz internal clock (T = 20 ns)
*/
`ifndef NAND_SEQ_MAP_VH
`define NAND_SEQ_MAP_VH

// register byte offsets
`define NBT_REG_CTRL        4'h0
`define NBT_REG_CMD         4'h4
`define NBT_REG_STATUS      4'h8
`define NBT_REG_RDATA       4'hc

// control fields
`define NBT_CTRL_WB_LSB     0
`define NBT_CTRL_WHR_LSB    2
`define NBT_CTRL_RHW_LSB    4
`define NBT_CTRL_ADL_LSB    6
`define NBT_CTRL_MODE_LSB   8
`define NBT_CTRL_KEEPCE_BIT 16
`define NBT_CTRL_RESET      17'h00000

// command fields and operation codes
`define NBT_CMD_OP_LSB      8
`define NBT_CMD_REP_LSB     16
`define NBT_OP_CMD          3'h0
`define NBT_OP_ADDR         3'h1
`define NBT_OP_WDATA        3'h2
`define NBT_OP_RDATA        3'h3
`define NBT_OP_WAITRDY      3'h4

// serial access modes
`define NBT_SAM_CONV        2'h0
`define NBT_SAM_EDO         2'h1
`define NBT_SAM_EXT_EDO     2'h2

// basic intervals in periods T of the internal clock
`define NBT_T_CYCLES        8'h01
`define NBT_LATCH_SETUP_T   8'h02
`define NBT_LATCH_HOLD_T    8'h02
`define NBT_CE_SETUP_T      8'h02
`define NBT_CE_HOLD_T       8'h02
`define NBT_DATA_SETUP_T    8'h01
`define NBT_DATA_HOLD_T     8'h01
`define NBT_READY_TO_RE_T   8'h03

// configurable turnarounds, multiples of 2T for codes 0..3
`define NBT_WB_M0           8'h0e
`define NBT_WB_M1           8'h16
`define NBT_WB_M2           8'h1e
`define NBT_WB_M3           8'h26
`define NBT_WHR_M0          8'h08
`define NBT_WHR_M1          8'h10
`define NBT_WHR_M2          8'h18
`define NBT_WHR_M3          8'h20
`define NBT_RHW_M0          8'h04
`define NBT_RHW_M1          8'h08
`define NBT_RHW_M2          8'h0c
`define NBT_RHW_M3          8'h14
`define NBT_ADL_M0          8'h00
`define NBT_ADL_M1          8'h08
`define NBT_ADL_M2          8'h10
`define NBT_ADL_M3          8'h18

`endif

// ### verilog/interval_timer.v
/*
  interval_timer: loadable down counter that flags the last cycle of an
  interval; assumes the loader holds its state for the loaded length
*/
`timescale 1ns/1ns
`default_nettype none

module interval_timer #(
  parameter W = 8
) (
  input  wire         ref_clk,
  input  wire         resetn,
  input  wire         clk_en,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output wire         done
);

  reg [W-1:0] cnt;

  // a load of n keeps done low for n-1 cycles; it stops at one, never wraps
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= {W{1'b0}};
    end else if (clk_en) begin
      if (load) begin
        cnt <= load_val;
      end else if (cnt > {{(W-1){1'b0}}, 1'b1}) begin
        cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign done = (cnt <= {{(W-1){1'b0}}, 1'b1});

endmodule // interval_timer

`default_nettype wire

// ### verilog/nand_bus_timing_sequencer.v
/*
  nand_bus_timing_sequencer: drives the strobe and latch sequence of a raw
  parallel nand flash bus, with an avalon-mm register slave (waitrequest).
  assumes one 50 MHz clock; flash pins are asynchronous and are synchronised.
// Functional notes
// - every bus interval is a whole count of internal clock periods T
// - cmd_latch_en set up two periods before and held two after write strobe
// - chip_enable asserted two periods before strobes, kept two periods after
// - write_strobe_n low one period, then high at least one period
// - addr_latch_en set up two periods before and held two after write strobe
// - write data stable one period before strobe rises, held one period after
// - three periods of ready before rd_strobe_n goes low
// - rd_strobe_n low one period, then high one period
// - successive read cycles repeat every two periods
// - successive write cycles repeat every two periods
// - write strobe rise to busy wait selectable 14/22/30/38 times 2T
// - write strobe rise to read strobe fall selectable 8/16/24/32 times 2T
// - read strobe rise to write strobe fall selectable 4/8/12/20 times 2T
// - last address to first data load selectable 0/8/16/24 times 2T
// - conventional, edo and extended edo serial read access modes
*/
`timescale 1ns/1ns
`default_nettype none
`include "nand_seq_map.vh"

module nand_bus_timing_sequencer (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        clk_en,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         chip_enable,
  output reg         cmd_latch_en,
  output reg         addr_latch_en,
  output reg         write_strobe_n,
  output reg         rd_strobe_n,
  input  wire [7:0]  flash_data_in,
  output reg  [7:0]  flash_data_out,
  output reg         flash_data_oe_n,
  input  wire        ready_busy_n
);

  localparam [9:0] S_IDLE     = 10'h001;
  localparam [9:0] S_GUARD    = 10'h002;
  localparam [9:0] S_SETUP    = 10'h004;
  localparam [9:0] S_WSTROBE  = 10'h008;
  localparam [9:0] S_WHOLD    = 10'h010;
  localparam [9:0] S_RB_WAIT  = 10'h020;
  localparam [9:0] S_RB_SETTL = 10'h040;
  localparam [9:0] S_RLOW     = 10'h080;
  localparam [9:0] S_RHIGH    = 10'h100;
  localparam [9:0] S_CE_OFF   = 10'h200;

  reg  [9:0]  state;
  reg  [16:0] ctrl;
  reg  [23:0] cmd_reg;
  reg  [2:0]  op;
  reg  [7:0]  op_byte;
  reg  [7:0]  rem;
  reg  [7:0]  since_we;
  reg  [7:0]  since_re;
  reg         last_write;
  reg         last_read;
  reg         last_addr;
  reg         rb_s1;
  reg         rb_s2;
  reg  [7:0]  data_s1;
  reg  [7:0]  data_s2;
  reg  [3:0]  cap;
  reg  [7:0]  rd_data;
  reg  [7:0]  rd_count;
  reg  [31:0] rd_mux;
  reg         tmr_load;
  reg  [7:0]  tmr_val;
  reg         guard_ok;
  wire        tmr_done;

  // turnaround code to cycles: multiple of 2T, T being one clock
  function [7:0] two_t;
    input [7:0] mult;
    begin
      two_t = {mult[6:0], 1'b0};
    end
  endfunction

  function [7:0] pick;
    input [1:0] code;
    input [7:0] m0;
    input [7:0] m1;
    input [7:0] m2;
    input [7:0] m3;
    begin
      case (code)
        2'h0:    pick = two_t(m0);
        2'h1:    pick = two_t(m1);
        2'h2:    pick = two_t(m2);
        default: pick = two_t(m3);
      endcase
    end
  endfunction

  wire [7:0] wb_cyc  = pick(ctrl[`NBT_CTRL_WB_LSB +: 2], `NBT_WB_M0, `NBT_WB_M1,
                            `NBT_WB_M2, `NBT_WB_M3);
  wire [7:0] whr_cyc = pick(ctrl[`NBT_CTRL_WHR_LSB +: 2], `NBT_WHR_M0, `NBT_WHR_M1,
                            `NBT_WHR_M2, `NBT_WHR_M3);
  wire [7:0] rhw_cyc = pick(ctrl[`NBT_CTRL_RHW_LSB +: 2], `NBT_RHW_M0, `NBT_RHW_M1,
                            `NBT_RHW_M2, `NBT_RHW_M3);
  wire [7:0] adl_cyc = pick(ctrl[`NBT_CTRL_ADL_LSB +: 2], `NBT_ADL_M0, `NBT_ADL_M1,
                            `NBT_ADL_M2, `NBT_ADL_M3);
  wire [1:0] sam     = ctrl[`NBT_CTRL_MODE_LSB +: 2];
  wire       keep_ce = ctrl[`NBT_CTRL_KEEPCE_BIT];
  wire       rb_ready = rb_s2;
  wire       is_latch = (op == `NBT_OP_CMD) || (op == `NBT_OP_ADDR);
  wire       is_wr    = is_latch || (op == `NBT_OP_WDATA);

  // bus decode; a command write is only answered while the sequencer is idle
  wire       reg_hit  = (avs_address[1:0] == 2'h0);
  wire       cmd_hit  = reg_hit && (avs_address == `NBT_REG_CMD);
  wire       ctrl_hit = reg_hit && (avs_address == `NBT_REG_CTRL);
  wire       cmd_pend = avs_write && cmd_hit;
  wire       can_ack  = !(cmd_pend && (state != S_IDLE));
  wire       wr_go    = avs_write && !avs_waitrequest;
  wire       start    = wr_go && cmd_hit;

  interval_timer #(
    .W (8)
  ) u_timer (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // turnaround checks before a new strobe may be scheduled
  always @* begin
    guard_ok = 1'b1;
    if (is_wr) begin
      if (last_read && (since_re < rhw_cyc))
        guard_ok = 1'b0;
      if ((op == `NBT_OP_WDATA) && last_addr && (since_we < adl_cyc))
        guard_ok = 1'b0;
    end else if (op == `NBT_OP_RDATA) begin
      if (last_write && (since_we < whr_cyc))
        guard_ok = 1'b0;
    end else begin
      if (last_write && (since_we < wb_cyc))
        guard_ok = 1'b0;
    end
  end

  // interval lengths loaded on state entry, all in whole clocks
  always @* begin
    tmr_load = 1'b0;
    tmr_val  = 8'h00;
    case (state)
      S_IDLE: begin
        if (!start && chip_enable && !keep_ce && !cmd_pend) begin
          tmr_load = 1'b1;
          tmr_val  = `NBT_CE_HOLD_T;
        end
      end
      S_GUARD: begin
        if (guard_ok && is_wr) begin
          tmr_load = 1'b1;
          tmr_val  = (is_latch || !chip_enable) ? `NBT_LATCH_SETUP_T
                                                : `NBT_DATA_SETUP_T;
        end else if (guard_ok && (op == `NBT_OP_RDATA)) begin
          tmr_load = 1'b1;
          tmr_val  = `NBT_READY_TO_RE_T;
        end
      end
      S_RB_SETTL: begin
        if (!rb_ready) begin
          tmr_load = 1'b1;
          tmr_val  = `NBT_READY_TO_RE_T;
        end
      end
      S_WSTROBE: begin
        tmr_load = 1'b1;
        tmr_val  = is_latch ? `NBT_LATCH_HOLD_T : `NBT_DATA_HOLD_T;
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // pin synchronisers: only the second stage is read by the sequencer
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rb_s1   <= 1'b0;
      rb_s2   <= 1'b0;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
    end else if (clk_en) begin
      rb_s1   <= ready_busy_n;
      rb_s2   <= rb_s1;
      data_s1 <= flash_data_in;
      data_s2 <= data_s1;
    end
  end

  // register file and avalon answer; one wait cycle (more while a command write waits for idle), then one ready cycle
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl            <= `NBT_CTRL_RESET;
      cmd_reg         <= 24'h000000;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (clk_en) begin
      if ((avs_read || avs_write) && avs_waitrequest && can_ack) begin
        avs_waitrequest <= 1'b0;
        if (avs_read)
          avs_readdata <= rd_mux;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (wr_go && ctrl_hit) begin
        if (avs_byteenable[0]) ctrl[7:0]  <= avs_writedata[7:0];
        if (avs_byteenable[1]) ctrl[15:8] <= avs_writedata[15:8];
        if (avs_byteenable[2]) ctrl[16]   <= avs_writedata[16];
      end
      if (start)
        cmd_reg <= avs_writedata[23:0];
    end
  end

  // read mux; unmapped or misaligned addresses read zero
  // busy also spans the capture pipeline, so rdata and the count are final when it clears
  always @* begin
    rd_mux = 32'h00000000;
    if (reg_hit) begin
      case (avs_address)
        `NBT_REG_CTRL:   rd_mux = {15'h0000, ctrl};
        `NBT_REG_CMD:    rd_mux = {8'h00, cmd_reg};
        `NBT_REG_STATUS: rd_mux = {16'h0000, rd_count, 5'h00, chip_enable,
                                   rb_ready, (state != S_IDLE) || (cap != 4'h0)};
        `NBT_REG_RDATA:  rd_mux = {24'h000000, rd_data};
        default:         rd_mux = 32'h00000000;
      endcase
    end
  end

  // elapsed clocks since the last strobe rise, saturating at the top
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      since_we <= 8'hff;
      since_re <= 8'hff;
    end else if (clk_en) begin
      if (state == S_WSTROBE)
        since_we <= 8'h00;
      else if (since_we != 8'hff)
        since_we <= since_we + 8'h01;
      if (state == S_RLOW)
        since_re <= 8'h00;
      else if (since_re != 8'hff)
        since_re <= since_re + 8'h01;
    end
  end

  // read capture; edo modes sample later since the flash keeps data longer
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cap      <= 4'h0;
      rd_data  <= 8'h00;
      rd_count <= 8'h00;
    end else if (clk_en) begin
      cap <= {cap[2:0], (state == S_RLOW)};
      if (((sam == `NBT_SAM_CONV) && cap[1]) ||
          ((sam == `NBT_SAM_EDO) && cap[2]) ||
          (sam[1] && cap[3])) begin
        rd_data  <= data_s2;
        rd_count <= rd_count + 8'h01;
      end
    end
  end

  // bus sequencer; every output is a flop set on the edge it must change
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state           <= S_IDLE;
      op              <= `NBT_OP_CMD;
      op_byte         <= 8'h00;
      rem             <= 8'h00;
      last_write      <= 1'b0;
      last_read       <= 1'b0;
      last_addr       <= 1'b0;
      chip_enable     <= 1'b0;
      cmd_latch_en    <= 1'b0;
      addr_latch_en   <= 1'b0;
      write_strobe_n  <= 1'b1;
      rd_strobe_n     <= 1'b1;
      flash_data_out  <= 8'h00;
      flash_data_oe_n <= 1'b1;
    end else if (clk_en) begin
      case (state)
        S_IDLE: begin
          if (start) begin
            op      <= avs_writedata[`NBT_CMD_OP_LSB +: 3];
            op_byte <= avs_writedata[7:0];
            rem     <= avs_writedata[`NBT_CMD_REP_LSB +: 8];
            state   <= S_GUARD;
          end else if (chip_enable && !keep_ce && !cmd_pend) begin
            state <= S_CE_OFF;
          end
        end
        S_GUARD: begin
          if (guard_ok) begin
            if (is_wr) begin
              chip_enable     <= 1'b1;
              cmd_latch_en    <= (op == `NBT_OP_CMD);
              addr_latch_en   <= (op == `NBT_OP_ADDR);
              flash_data_out  <= op_byte;
              flash_data_oe_n <= 1'b0;
              state           <= S_SETUP;
            end else if (op == `NBT_OP_RDATA) begin
              chip_enable <= 1'b1;
              state       <= S_RB_SETTL;
            end else begin
              state <= S_RB_WAIT;
            end
          end
        end
        S_SETUP: begin
          if (tmr_done) begin
            write_strobe_n <= 1'b0;
            state          <= S_WSTROBE;
          end
        end
        S_WSTROBE: begin
          write_strobe_n <= 1'b1;
          last_write     <= 1'b1;
          last_read      <= 1'b0;
          last_addr      <= (op == `NBT_OP_ADDR);
          state          <= S_WHOLD;
        end
        S_WHOLD: begin
          if (tmr_done) begin
            if ((op == `NBT_OP_WDATA) && (rem != 8'h00)) begin
              rem            <= rem - 8'h01;
              write_strobe_n <= 1'b0;
              state          <= S_WSTROBE;
            end else begin
              cmd_latch_en    <= 1'b0;
              addr_latch_en   <= 1'b0;
              flash_data_oe_n <= 1'b1;
              state           <= S_IDLE;
            end
          end
        end
        S_RB_WAIT: begin
          if (rb_ready)
            state <= S_IDLE;
        end
        S_RB_SETTL: begin
          if (rb_ready && tmr_done) begin
            rd_strobe_n <= 1'b0;
            state       <= S_RLOW;
          end
        end
        S_RLOW: begin
          rd_strobe_n <= 1'b1;
          last_read   <= 1'b1;
          last_write  <= 1'b0;
          last_addr   <= 1'b0;
          state       <= S_RHIGH;
        end
        S_RHIGH: begin
          if (rem != 8'h00) begin
            rem         <= rem - 8'h01;
            rd_strobe_n <= 1'b0;
            state       <= S_RLOW;
          end else begin
            state <= S_IDLE;
          end
        end
        S_CE_OFF: begin
          if (tmr_done) begin
            chip_enable <= 1'b0;
            state       <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // nand_bus_timing_sequencer

`default_nettype wire

// ### verification/nand_seq_checker_asserts.sv
/*
  nand_seq_checker: pin timing of the nand bus timing sequencer, watched from
  the top ports; assumes ctrl is always written with every byte lane enabled
*/
`timescale 1ns/1ns
`default_nettype none
`include "nand_seq_map.vh"

module nand_seq_checker (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        chip_enable,
  input wire logic        cmd_latch_en,
  input wire logic        addr_latch_en,
  input wire logic        write_strobe_n,
  input wire logic        rd_strobe_n,
  input wire logic [7:0]  flash_data_out,
  input wire logic        flash_data_oe_n,
  input wire logic        ready_busy_n
);
  logic [16:0] ctrl;
  logic [7:0]  since_we, since_re, rdy_run;
  logic        last_addr;
  logic [8:0]  whr_min, rhw_min, adl_min;

  function automatic logic [8:0] twice(input logic [1:0] c, input logic [7:0] m0, m1, m2, m3);
    twice = {c == 2'h0 ? m0 : c == 2'h1 ? m1 : c == 2'h2 ? m2 : m3, 1'b0};
  endfunction

  // minimum turnarounds in cycles, from the shadowed control codes
  assign whr_min = twice(ctrl[3:2], `NBT_WHR_M0, `NBT_WHR_M1, `NBT_WHR_M2, `NBT_WHR_M3);
  assign rhw_min = twice(ctrl[5:4], `NBT_RHW_M0, `NBT_RHW_M1, `NBT_RHW_M2, `NBT_RHW_M3);
  assign adl_min = twice(ctrl[7:6], `NBT_ADL_M0, `NBT_ADL_M1, `NBT_ADL_M2, `NBT_ADL_M3);

  // distance counters saturate, so a long idle spell never wraps into a short one
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl      <= `NBT_CTRL_RESET;
      since_we  <= 8'hff;
      since_re  <= 8'hff;
      rdy_run   <= 8'h00;
      last_addr <= 1'b0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == `NBT_REG_CTRL)
        ctrl <= avs_writedata[16:0];
      since_we  <= !write_strobe_n ? 8'h00 : since_we + {7'h00, since_we != 8'hff};
      since_re  <= !rd_strobe_n ? 8'h00 : since_re + {7'h00, since_re != 8'hff};
      rdy_run   <= !ready_busy_n ? 8'h00 : rdy_run + {7'h00, rdy_run != 8'hff};
      if (!write_strobe_n)
        last_addr <= addr_latch_en;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_we_pulse_one: assert property (!write_strobe_n |=> write_strobe_n)
    else $error("write strobe low for more than one cycle");
  a_re_pulse_one: assert property (!rd_strobe_n |=> rd_strobe_n)
    else $error("read strobe low for more than one cycle");
  a_cle_setup_hold: assert property ($fell(write_strobe_n) && cmd_latch_en |->
    $past(cmd_latch_en, 2) ##1 cmd_latch_en [*2]) else $error("command latch window short");
  a_ale_setup_hold: assert property ($fell(write_strobe_n) && addr_latch_en |->
    $past(addr_latch_en, 2) ##1 addr_latch_en [*2]) else $error("address latch window short");
  a_ce_around_strobe: assert property ($fell(write_strobe_n) || $fell(rd_strobe_n) |->
    $past(chip_enable, 2) ##1 chip_enable [*2]) else $error("chip enable window short");
  a_data_window: assert property ($rose(write_strobe_n) |->
    !flash_data_oe_n && $stable(flash_data_oe_n) && $stable(flash_data_out))
    else $error("write data not stable");
  a_ready_before_re: assert property ($fell(rd_strobe_n) |-> rdy_run >= 8'h03)
    else $error("read strobe too soon after ready");
  a_wr_to_rd: assert property ($fell(rd_strobe_n) |-> since_we >= whr_min)
    else $error("write to read turnaround short");
  a_rd_to_wr: assert property ($fell(write_strobe_n) |-> since_re >= rhw_min)
    else $error("read to write turnaround short");
  a_addr_to_data: assert property ($fell(write_strobe_n) && !cmd_latch_en &&
    !addr_latch_en && last_addr |-> since_we >= adl_min) else $error("address to data gap short");

  c_read_burst: cover property ($fell(rd_strobe_n) ##2 $fell(rd_strobe_n));
  c_addr_then_data: cover property ($fell(write_strobe_n) && !addr_latch_en && last_addr);
  c_flash_busy: cover property ($fell(ready_busy_n));
endmodule // nand_seq_checker
`default_nettype wire

// ### verification/nand_flash_model.sv
/*
  nand_flash_model: behavioural flash on the far side of the sequencer;
  assumes the bench resolves the shared data pins from the design's enable
*/
`timescale 1ns/1ns
`default_nettype none

module nand_flash_model #(
  parameter logic [7:0] BUSY_CMD   = 8'h30, // arbitrary command byte that starts a busy spell
  parameter logic [7:0] FIRST_BYTE = 8'h3c,
  parameter int         BUSY_DLY   = 100,
  parameter int         BUSY_LEN   = 2000
) (
  input wire logic       chip_enable,
  input wire logic       cmd_latch_en,
  input wire logic       write_strobe_n,
  input wire logic       rd_strobe_n,
  input wire logic [7:0] flash_data_out,
  output var logic [7:0] flash_q,
  output var logic       ready_busy_n
);
  logic [7:0] next_byte = FIRST_BYTE;

  initial begin
    flash_q = 8'hff;
    ready_busy_n = 1'b1;
  end

  // every read strobe fall while chip_enable is high presents the next byte of a counting pattern
  always @(negedge rd_strobe_n) begin
    if (chip_enable) begin
      flash_q <= next_byte;
      next_byte <= next_byte + 8'h11;
    end
  end

  // once deselected past its hold time, stale data must not look valid
  always @(negedge chip_enable) begin
    #60;
    if (!chip_enable)
      flash_q = ~flash_q;
  end

  // a latched busy command pulls the open-drain ready line low for a while
  always @(posedge write_strobe_n) begin
    if (chip_enable && cmd_latch_en && flash_data_out === BUSY_CMD) begin
      #(BUSY_DLY) ready_busy_n = 1'b0;
      #(BUSY_LEN) ready_busy_n = 1'b1;
    end
  end
endmodule // nand_flash_model
`default_nettype wire

// ### verification/tb_nand_bus_timing_sequencer.sv
/*
  tb_nand_bus_timing_sequencer: register bus driver, queue model of every
  flash write transfer, read count, turnaround sweeps; assumes nand_flash_model on the pins
*/
`timescale 1ns/1ns
`default_nettype none
`include "nand_seq_map.vh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t: value differs", $time); end end

module tb_nand_bus_timing_sequencer;
  localparam logic [7:0] FIRST = 8'h3c;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd, seed = 32'd99799;
  logic        avs_waitrequest, chip_enable, cmd_latch_en, addr_latch_en;
  logic        write_strobe_n, rd_strobe_n, flash_data_oe_n, ready_busy_n;
  logic [7:0]  flash_data_out, flash_q, flash_bus, e;
  logic [9:0]  wq[$];
  int          miscompares = 0, comparisons = 0, rd_total = 0, rd_seen = 0;
  int          wbm[4] = '{`NBT_WB_M0, `NBT_WB_M1, `NBT_WB_M2, `NBT_WB_M3};
  time         t_we = 0;

  // the flash drives the pins only while the design has let go of them
  assign flash_bus = flash_data_oe_n ? flash_q : flash_data_out;

  nand_bus_timing_sequencer u_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .chip_enable(chip_enable), .cmd_latch_en(cmd_latch_en),
    .addr_latch_en(addr_latch_en), .write_strobe_n(write_strobe_n), .rd_strobe_n(rd_strobe_n),
    .flash_data_in(flash_bus), .flash_data_out(flash_data_out),
    .flash_data_oe_n(flash_data_oe_n), .ready_busy_n(ready_busy_n));

  nand_flash_model #(.FIRST_BYTE(FIRST)) u_flash (.chip_enable(chip_enable),
    .cmd_latch_en(cmd_latch_en), .write_strobe_n(write_strobe_n), .rd_strobe_n(rd_strobe_n),
    .flash_data_out(flash_data_out), .flash_q(flash_q), .ready_busy_n(ready_busy_n));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {seed[6:0], 1'b1};
  endfunction

  // one avalon access: hold everything until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  // start a flash operation and queue the transfers it must put on the pins
  task automatic op(input logic [2:0] c, input logic [7:0] b, input logic [7:0] rep);
    if (c == `NBT_OP_RDATA)
      rd_total += rep + 1;
    else if (c != `NBT_OP_WAITRDY)
      for (int i = 0; i <= rep; i++)
        wq.push_back({c == `NBT_OP_CMD, c == `NBT_OP_ADDR, b});
    bus(1'b1, `NBT_REG_CMD, {8'h00, rep, 5'h00, c, b}, rd);
  endtask

  task automatic idle();
    do bus(1'b0, `NBT_REG_STATUS, 32'h0, rd); while (rd[0] !== 1'b0);
  endtask

  // every cycle with the write strobe low must carry the next queued transfer
  always @(posedge ref_clk) begin
    if (resetn && rd_strobe_n === 1'b0)
      rd_seen++;
    if (resetn && write_strobe_n === 1'b0) begin
      t_we = $time;
      if (wq.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({cmd_latch_en, addr_latch_en, flash_data_out}, wq.pop_front())
    end
  end

  task summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #1000000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, `NBT_REG_CTRL, 32'h0, rd);
    `CHK(rd[16:0], `NBT_CTRL_RESET)
    // sweep every code of every turnaround and every read mode
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `NBT_REG_CTRL, {15'h0, c[0], 6'h0, {5{c[1:0]}}}, rd);
      bus(1'b0, `NBT_REG_CTRL, 32'h0, rd);
      `CHK(rd[16:0], {c[0], 6'h0, {5{c[1:0]}}})
      op(`NBT_OP_CMD, rnd(), 8'h00);
      op(`NBT_OP_ADDR, rnd(), 8'h00);
      op(`NBT_OP_ADDR, rnd(), 8'h00);
      op(`NBT_OP_WDATA, rnd(), 8'h02);
      op(`NBT_OP_RDATA, 8'h00, c == 0 ? 8'h03 : 8'h00);
      idle();
      `CHK(rd[15:8], rd_total[7:0])
      bus(1'b0, `NBT_REG_RDATA, 32'h0, rd);
      e = FIRST + 8'h11 * (rd_total - 1);
      `CHK(rd[7:0], e)
      op(`NBT_OP_CMD, rnd(), 8'h00);
      op(`NBT_OP_WAITRDY, 8'h00, 8'h00);
      idle();
      `CHK(($time - t_we) / 20 >= 2 * wbm[c], 1'b1)
      `CHK(($time - t_we) / 20 < 2 * wbm[c] + 16, 1'b1)
    end
    // a real busy spell: status must show the sequencer busy and the wait must outlast the spell
    op(`NBT_OP_CMD, 8'h30, 8'h00);
    op(`NBT_OP_WAITRDY, 8'h00, 8'h00);
    bus(1'b0, `NBT_REG_STATUS, 32'h0, rd);
    `CHK(rd[0], 1'b1)
    idle();
    `CHK(rd[1], 1'b1)
    `CHK(($time - t_we) >= 2100, 1'b1)
    // unmapped place: write ignored, read gives zero
    bus(1'b1, 4'h1, 32'hffffffff, rd);
    bus(1'b0, 4'h1, 32'h0, rd);
    `CHK(rd, 32'h0)
    `CHK(rd_seen, rd_total)
    `CHK(wq.size(), 0)
    summarize();
  end
endmodule // tb_nand_bus_timing_sequencer

bind nand_bus_timing_sequencer nand_seq_checker u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .chip_enable(chip_enable), .cmd_latch_en(cmd_latch_en),
  .addr_latch_en(addr_latch_en), .write_strobe_n(write_strobe_n), .rd_strobe_n(rd_strobe_n),
  .flash_data_out(flash_data_out), .flash_data_oe_n(flash_data_oe_n),
  .ready_busy_n(ready_busy_n));
`default_nettype wire
